// ===== include/sdr_pkg.sv
// What this block does
// - Write burst mode bit set makes writes single column; reads keep programmed length
// - ACTIVE to another bank accepted
// - Read with auto-precharge flag closes the row after the burst
// - First read element after CAS latency, then one per clock
// - Data lines float when a read burst completes
// - Full-page read runs until terminated, wrapping to column zero
// - New read truncates or follows earlier read seamlessly
// - Read accepted on any clock after a previous read
// - Byte mask suppresses read output with two-clock latency
// - Truncating write floats data lines if mask was active before
// - Byte mask applies to write input with zero latency
// - Burst terminate stops any read without auto-precharge, full-page included
// - Data lines driven and valid together from the same clock edge
// - Normal operation only with both operating mode bits zero
package sdr_pkg;
	localparam int COL_W = 8;
	localparam int ROW_W = 12;
	localparam int DATA_W = 16;
	localparam int BANKS = 4;
	localparam int FIFO_DEPTH = 4;
	localparam int AP_BIT = 10;
	// Mode field positions
	localparam int BL_LSB = 0;
	localparam int CL_LSB = 4;
	localparam int OPM_LOW = 7;
	localparam int OPM_HIGH = 8;
	localparam int WBM_BIT = 9;
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [2:0] CL_TWO = 3'h2;
	localparam logic [2:0] CL_THREE = 3'h3;
	localparam logic [1:0] MASK_LAT = 2'h2;
	// {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		SDR_CMD_MRS = 4'h0,
		SDR_CMD_REF = 4'h1,
		SDR_CMD_PRE = 4'h2,
		SDR_CMD_ACT = 4'h3,
		SDR_CMD_WR = 4'h4,
		SDR_CMD_RD = 4'h5,
		SDR_CMD_BST = 4'h6,
		SDR_CMD_NOP = 4'h7
	} sdr_cmd_t;
	localparam logic [11:0] MODE_RESET = 12'h000;
endpackage

// ===== logic/sdr_fifo.sv
`timescale 1ns/10ps
module sdr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_flush,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	always_comb
	begin
		o_in_ready = (count != (AW+1)'(DEPTH));
		o_out_valid = (count != '0);
		push = i_in_valid && o_in_ready;
		pop = o_out_valid && i_out_ready;
		next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
		if (i_flush)
		begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count = '0;
		end
		o_out_data = mem[rd_ptr];
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage needs no reset
	always_ff @(posedge i_clock)
	begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end
endmodule

// ===== logic/sdr_read_path.sv
`timescale 1ns/10ps
module sdr_read_path
	import sdr_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_we_n,
	input wire logic [ROW_W-1:0] i_addr,
	input wire logic [1:0] i_bank,
	input wire logic i_dqm,
	input wire logic [DATA_W-1:0] i_rd_data,
	input wire logic i_rd_valid,
	output logic o_rd_ready,
	output logic [DATA_W-1:0] o_dq,
	output logic o_dq_oe_n,
	output logic o_col_req,
	output logic [1:0] o_col_bank,
	output logic [COL_W-1:0] o_col_addr,
	output logic o_wr_single,
	output logic o_wr_accept,
	output logic o_auto_pre,
	output logic [1:0] o_auto_pre_bank,
	output logic [BANKS-1:0] o_row_open,
	output logic o_normal_mode
);
	// Two-flop synchronisers on every command, address, bank and mask pin
	logic [3:0] cmd_s1, cmd_s2, next_cmd_s1, next_cmd_s2;
	logic [ROW_W-1:0] addr_s1, addr_s2, next_addr_s1, next_addr_s2;
	logic [1:0] bank_s1, bank_s2, next_bank_s1, next_bank_s2;
	logic dqm_s1, dqm_s2, next_dqm_s1, next_dqm_s2;

	always_comb
	begin
		next_cmd_s1 = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
		next_cmd_s2 = cmd_s1;
		next_addr_s1 = i_addr;
		next_addr_s2 = addr_s1;
		next_bank_s1 = i_bank;
		next_bank_s2 = bank_s1;
		next_dqm_s1 = i_dqm;
		next_dqm_s2 = dqm_s1;
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			cmd_s1 <= 4'hf;
			cmd_s2 <= 4'hf;
			addr_s1 <= '0;
			addr_s2 <= '0;
			bank_s1 <= '0;
			bank_s2 <= '0;
			dqm_s1 <= 1'b1;
			dqm_s2 <= 1'b1;
		end
		else
		begin
			cmd_s1 <= next_cmd_s1;
			cmd_s2 <= next_cmd_s2;
			addr_s1 <= next_addr_s1;
			addr_s2 <= next_addr_s2;
			bank_s1 <= next_bank_s1;
			bank_s2 <= next_bank_s2;
			dqm_s1 <= next_dqm_s1;
			dqm_s2 <= next_dqm_s2;
		end
	end

	sdr_cmd_t cmd;
	always_comb
	begin
		// Chip deselect reads as no operation
		cmd = cmd_s2[3] ? SDR_CMD_NOP : sdr_cmd_t'(cmd_s2);
	end

	// Mode, open rows, burst state
	logic [11:0] mode, next_mode;
	logic [BANKS-1:0] row_open, next_row_open;
	logic burst_on, next_burst_on;
	logic [COL_W-1:0] col, next_col;
	logic [8:0] left, next_left;
	logic [1:0] bank, next_bank;
	logic ap, next_ap;
	logic pre_pend, next_pre_pend;
	logic [1:0] pre_bank, next_pre_bank;
	logic [8:0] blen;
	logic [COL_W-1:0] wrap_mask;

	always_comb
	begin
		unique case (mode[BL_LSB +: 3])
			3'h0: blen = 9'h001;
			3'h1: blen = 9'h002;
			3'h2: blen = 9'h004;
			3'h3: blen = 9'h008;
			default: blen = 9'h000;
		endcase
		wrap_mask = (mode[BL_LSB +: 3] == BL_FULL) ? 8'hff : COL_W'(blen - 9'h001);
		o_normal_mode = !mode[OPM_LOW] && !mode[OPM_HIGH];
		o_wr_single = mode[WBM_BIT];
		next_mode = mode;
		next_row_open = row_open;
		next_burst_on = burst_on;
		next_col = col;
		next_left = left;
		next_bank = bank;
		next_ap = ap;
		next_pre_pend = 1'b0;
		next_pre_bank = pre_bank;
		o_col_req = 1'b0;
		if (burst_on)
		begin
			o_col_req = 1'b1;
			next_col = (col & ~wrap_mask) | ((col + 8'h01) & wrap_mask);
			if (mode[BL_LSB +: 3] != BL_FULL)
			begin
				next_left = left - 9'h001;
				if (left == 9'h001)
				begin
					next_burst_on = 1'b0;
					next_pre_pend = ap;
					next_pre_bank = bank;
					if (ap)
						next_row_open[bank] = 1'b0;
				end
			end
		end
		unique case (cmd)
			SDR_CMD_MRS: next_mode = addr_s2;
			SDR_CMD_ACT: next_row_open[bank_s2] = 1'b1;
			SDR_CMD_PRE:
			begin
				if (addr_s2[AP_BIT])
					next_row_open = '0;
				else
					next_row_open[bank_s2] = 1'b0;
				if (!addr_s2[AP_BIT] && bank_s2 == bank && !ap)
					next_burst_on = 1'b0;
			end
			SDR_CMD_BST:
			begin
				if (!ap)
					next_burst_on = 1'b0;
			end
			SDR_CMD_WR: next_burst_on = 1'b0;
			SDR_CMD_RD:
			begin
				if (o_normal_mode)
				begin
					next_burst_on = 1'b1;
					next_col = addr_s2[COL_W-1:0];
					next_bank = bank_s2;
					next_ap = addr_s2[AP_BIT];
					next_left = blen;
				end
			end
			default:
			begin
			end
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			mode <= MODE_RESET;
			row_open <= '0;
			burst_on <= 1'b0;
			col <= '0;
			left <= '0;
			bank <= '0;
			ap <= 1'b0;
			pre_pend <= 1'b0;
			pre_bank <= '0;
		end
		else
		begin
			mode <= next_mode;
			row_open <= next_row_open;
			burst_on <= next_burst_on;
			col <= next_col;
			left <= next_left;
			bank <= next_bank;
			ap <= next_ap;
			pre_pend <= next_pre_pend;
			pre_bank <= next_pre_bank;
		end
	end

	always_comb
	begin
		o_col_bank = bank;
		o_col_addr = col;
		o_row_open = row_open;
		o_auto_pre = pre_pend;
		o_auto_pre_bank = pre_bank;
	end

	// Output pipe: array data enters FIFO, leaves at CAS latency
	logic [DATA_W-1:0] fifo_data;
	logic fifo_valid;
	logic pop;
	logic [2:0] lat_pipe, next_lat_pipe;
	logic [1:0] mask_pipe, next_mask_pipe;
	logic dq_on, next_dq_on;
	logic [DATA_W-1:0] dq, next_dq;
	logic wr_cut;
	logic cut_tail, next_cut_tail;
	logic fifo_flush;

	sdr_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_flush(fifo_flush),
		.i_in_valid(i_rd_valid),
		.o_in_ready(o_rd_ready),
		.i_in_data(i_rd_data),
		.o_out_valid(fifo_valid),
		.i_out_ready(pop),
		.o_out_data(fifo_data)
	);

	always_comb
	begin
		// Pipe stage k set when column issued k+1 cycles ago
		next_lat_pipe = {lat_pipe[1:0], o_col_req};
		wr_cut = (cmd == SDR_CMD_WR);
		// Word fetched just before the cut still lands a cycle later
		next_cut_tail = wr_cut;
		fifo_flush = wr_cut || cut_tail;
		if (wr_cut)
			next_lat_pipe = '0;
		next_mask_pipe = {mask_pipe[0], dqm_s2};
		// One cycle of array fetch, then CL-1 more; the FIFO takes the slack
		pop = (mode[CL_LSB +: 3] == CL_THREE) ? lat_pipe[2] : lat_pipe[1];
		next_dq_on = pop && fifo_valid && !mask_pipe[MASK_LAT-1] && !wr_cut;
		next_dq = (pop && fifo_valid) ? fifo_data : dq;
		if (!next_dq_on)
			next_dq = dq;
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			lat_pipe <= '0;
			mask_pipe <= '0;
			dq_on <= 1'b0;
			dq <= '0;
			cut_tail <= 1'b0;
		end
		else
		begin
			lat_pipe <= next_lat_pipe;
			mask_pipe <= next_mask_pipe;
			dq_on <= next_dq_on;
			dq <= next_dq;
			cut_tail <= next_cut_tail;
		end
	end

	// Input mask has no latency; cutting a live read needs the mask a cycle ahead
	logic wr_live;
	logic wr_ok;
	always_comb
	begin
		wr_live = burst_on || (lat_pipe != '0);
		wr_ok = !wr_live || mask_pipe[0];
		o_wr_accept = wr_cut && o_normal_mode && !dqm_s2 && wr_ok;
	end

	always_comb
	begin
		o_dq = dq;
		o_dq_oe_n = !dq_on;
	end
endmodule

// ===== test/sdr_array_model.sv
`timescale 1ns/10ps
module sdr_array_model
	import sdr_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_col_req,
	input wire logic [1:0] i_col_bank,
	input wire logic [COL_W-1:0] i_col_addr,
	input wire logic i_ready,
	output logic o_valid,
	output logic [DATA_W-1:0] o_data
);
	// Released bus shows the inverse word, never a stale copy
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_valid <= 1'b0;
			o_data <= 16'h0000;
		end
		else if (i_col_req)
		begin
			o_valid <= 1'b1;
			o_data <= {4'h5, 2'h0, i_col_bank, i_col_addr};
		end
		else if (o_valid && i_ready)
		begin
			o_valid <= 1'b0;
			o_data <= ~o_data;
		end
	end
endmodule

// ===== test/sdr_read_path_assertions.sv
`timescale 1ns/10ps
module sdr_rp_checker
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_we_n,
	input wire logic i_dqm,
	input wire logic o_dq_oe_n,
	input wire logic o_col_req,
	input wire logic o_wr_accept,
	input wire logic o_auto_pre,
	input wire logic [1:0] o_auto_pre_bank,
	input wire logic [3:0] o_row_open,
	input wire logic o_normal_mode
);
	logic rd_pins;
	logic wr_pins;
	assign rd_pins = !i_cs_n && i_ras_n && !i_cas_n && i_we_n;
	assign wr_pins = !i_cs_n && i_ras_n && !i_cas_n && !i_we_n;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	sequence burst_over;
		$fell(o_col_req) ##1 !o_col_req [*5];
	endsequence
	sequence mask_held;
		i_dqm [*6];
	endsequence
	data_drive_a: assert property (!o_dq_oe_n |-> $past(o_col_req, 3) || $past(o_col_req, 4))
		else $error("drive without fetch");
	read_cause_a: assert property ($rose(o_col_req) |-> $past(rd_pins, 3) || $past(rd_pins, 4))
		else $error("fetch without read");
	write_mode_a: assert property (o_wr_accept |-> o_normal_mode)
		else $error("write outside normal mode");
	write_cause_a: assert property (o_wr_accept |-> $past(wr_pins, 2) || $past(wr_pins, 3))
		else $error("write without pins");
	write_mask_a: assert property (o_wr_accept |-> !$past(i_dqm, 2))
		else $error("masked write accepted");
	auto_close_a: assert property (o_auto_pre |-> ##[0:1] !o_row_open[o_auto_pre_bank])
		else $error("row left open");
	mask_out_a: assert property (mask_held |-> o_dq_oe_n)
		else $error("masked output driven");
	write_float_a: assert property ($past(i_dqm) && wr_pins |-> ##4 o_dq_oe_n)
		else $error("no float on write");
	burst_end_a: assert property (burst_over |-> o_dq_oe_n)
		else $error("no float after burst");
endmodule
bind sdr_read_path sdr_rp_checker u_chk (.*);

// ===== test/tb.sv
`timescale 1ns/10ps
module tb;
	import sdr_pkg::*;
	logic i_clock, i_rst, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_dqm, i_rd_valid, o_rd_ready;
	logic o_dq_oe_n, o_col_req, o_wr_single, o_wr_accept, o_auto_pre, o_normal_mode;
	logic [ROW_W-1:0] i_addr;
	logic [1:0] i_bank, o_col_bank, o_auto_pre_bank;
	logic [DATA_W-1:0] i_rd_data, o_dq;
	logic [COL_W-1:0] o_col_addr;
	logic [BANKS-1:0] o_row_open;
	int n_mismatch = 0, checks_done = 0, tick = 0, mark = 0, first = 0, nwr = 0, nap = 0, lat;
	logic [DATA_W-1:0] got[$];
	sdr_read_path uut (.*);
	sdr_array_model u_arr (.i_clock(i_clock), .i_rst(i_rst), .i_col_req(o_col_req),
		.i_col_bank(o_col_bank), .i_col_addr(o_col_addr), .i_ready(o_rd_ready),
		.o_valid(i_rd_valid), .o_data(i_rd_data));
	initial
	begin
		i_clock = 0;
		forever #2 i_clock = ~i_clock;
	end
	always @(posedge i_clock)
	begin
		tick++;
	end
	always @(negedge i_clock)
	begin
		nwr += (o_wr_accept === 1'b1);
		nap += (o_auto_pre === 1'b1);
		if (o_dq_oe_n === 1'b0)
		begin
			if (got.size() == 0)
				first = tick;
			got.push_back(o_dq);
		end
	end
	task stop_test;
		if (n_mismatch == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task cmd(input sdr_cmd_t c, input logic [1:0] b, input logic [11:0] a, input int g);
		@(negedge i_clock);
		{i_cs_n, i_ras_n, i_cas_n, i_we_n} = c;
		i_bank = b;
		i_addr = a;
		mark = tick;
		@(negedge i_clock);
		{i_cs_n, i_ras_n, i_cas_n, i_we_n} = SDR_CMD_NOP;
		repeat (g) @(negedge i_clock);
	endtask
	// Bounded wait: an ignored read never drives
	task drain;
		int k;
		k = 0;
		while ((got.size() == 0 || o_dq_oe_n !== 1'b1) && k < 60)
		begin
			@(negedge i_clock);
			k++;
		end
		repeat (8) @(negedge i_clock);
	endtask
	task seq(input logic [1:0] b, input logic [7:0] c, input int len, input int n, input int s);
		logic [7:0] k;
		for (int i = 0; i < n; i++)
		begin
			k = (c & ~8'(len - 1)) | ((c + 8'(i)) & 8'(len - 1));
			chk("word", {4'h5, 2'h0, b, k}, got[s + i]);
		end
	endtask
	initial
	begin
		#20000;
		n_mismatch++;
		stop_test;
	end
	initial
	begin
		i_rst = 1;
		i_dqm = 0;
		i_addr = 0;
		i_bank = 0;
		{i_cs_n, i_ras_n, i_cas_n, i_we_n} = SDR_CMD_NOP;
		repeat (6) @(negedge i_clock);
		i_rst = 0;
		chk("oe_n", 16'h1, 16'(o_dq_oe_n));
		chk("normal", 16'h1, 16'(o_normal_mode));
		cmd(SDR_CMD_MRS, 0, 12'h222, 3);
		chk("single", 16'h1, 16'(o_wr_single));
		cmd(SDR_CMD_ACT, 1, 12'h123, 3);
		cmd(SDR_CMD_ACT, 2, 12'h040, 3);
		chk("rows", 16'h6, 16'(o_row_open));
		cmd(SDR_CMD_WR, 1, 0, 3);
		chk("wr", 16'h1, 16'(nwr));
		got.delete();
		cmd(SDR_CMD_RD, 1, 12'h005, 0);
		drain;
		chk("count", 16'h4, 16'(got.size()));
		seq(1, 8'h05, 4, 4, 0);
		lat = first - mark;
		cmd(SDR_CMD_MRS, 0, 12'h032, 3);
		chk("single", 16'h0, 16'(o_wr_single));
		got.delete();
		cmd(SDR_CMD_RD, 1, 12'h005, 0);
		drain;
		chk("lat", 16'(lat + 1), 16'(first - mark));
		cmd(SDR_CMD_MRS, 0, 12'h022, 3);
		got.delete();
		cmd(SDR_CMD_RD, 1, 0, 0);
		cmd(SDR_CMD_RD, 2, 12'h010, 0);
		drain;
		seq(2, 8'h10, 4, 4, got.size() - 4);
		got.delete();
		cmd(SDR_CMD_RD, 2, 12'h403, 0);
		drain;
		chk("ap", 16'h1, 16'(nap));
		chk("rows", 16'h2, 16'(o_row_open));
		cmd(SDR_CMD_MRS, 0, 12'h027, 3);
		got.delete();
		cmd(SDR_CMD_RD, 1, 12'h0fe, 6);
		cmd(SDR_CMD_BST, 1, 0, 0);
		drain;
		seq(1, 8'hfe, 256, 4, 0);
		chk("stop", 16'h1, 16'(got.size() < 20));
		got.delete();
		cmd(SDR_CMD_RD, 1, 12'h010, 4);
		cmd(SDR_CMD_PRE, 1, 0, 0);
		drain;
		chk("cut", 16'h6, 16'(got.size()));
		chk("rows", 16'h0, 16'(o_row_open));
		cmd(SDR_CMD_ACT, 1, 12'h123, 3);
		i_dqm = 1;
		got.delete();
		cmd(SDR_CMD_RD, 1, 0, 20);
		chk("masked", 16'h0, 16'(got.size()));
		cmd(SDR_CMD_WR, 1, 0, 0);
		i_dqm = 0;
		cmd(SDR_CMD_BST, 1, 0, 8);
		chk("wr", 16'h1, 16'(nwr));
		chk("float", 16'h0, 16'(got.size()));
		cmd(SDR_CMD_MRS, 0, 12'h0a2, 3);
		chk("normal", 16'h0, 16'(o_normal_mode));
		cmd(SDR_CMD_RD, 1, 0, 0);
		drain;
		chk("ignored", 16'h0, 16'(got.size()));
		stop_test;
	end
endmodule
